// file: verilog/iwpc_regs.sv
// Input warning detection, event logging, current reference and pin pair configuration.
// Assumes an upstream command layer delivering one decoded command per strobe.
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// What this block does
// [R1] Overpower sets unknown, input and overpower bits
// [R2] Overcurrent sets unknown, input and overcurrent bits
// [R3] Either warning may set energy overflow bit
// [R4] Log each warning with identifier and stamp
// [R5] Pointer steps below six, else wraps zero
// [R6] Pointer holds when no log slot free
// [R7] Alert only if unmasked and pin selected
// [R8] Overcurrent warns when current exceeds limit
// [R9] Clear needs current below and clear command
// [R10] Limit: eight bits in word, reset FFh
// [R11] Limit reached at code 5Dh, word access
// [R12] Reference: six bits, reset 32h, code E0h
// [R13] Reference code drives comparator threshold DAC
// [R14] Host unlocks write protect before writing; this block has no write protect and accepts every write to a known code
// [R15] Pin pair register at code E1h
// [R16] Bits 7:5 select pin one function
// [R17] Bit 4 holds pin one level
// [R18] Bits 3:1 pin two, bit 0 level
module iwpc_regs
   import iwpc_pkg::*;
#(
   parameter int STAMP_DIV = STAMP_TICK_CYCLES
) (
   // Clock and reset
   input  wire logic        SYS_CLK,
   input  wire logic        RESETN,
   // Command port
   input  wire logic        CMD_VALID,
   input  wire logic        CMD_WRITE,
   input  wire logic [7:0]  CMD_CODE,
   input  wire logic [15:0] CMD_WDATA,
   output logic             CMD_DONE,
   output logic             CMD_ERR,
   output logic      [15:0] RD_DATA,
   // Telemetry
   input  wire logic        OVERPOWER_DETECT,
   input  wire logic        IMON_VALID,
   input  wire logic [7:0]  IMON_VALUE,
   input  wire logic        ENERGY_OVERFLOW,
   // Alert
   input  wire logic        ALERT_MASK_INPUT,
   input  wire logic        ALERT_PIN_SELECTED,
   output logic             ALERT_LINE_N_O,
   output logic             ALERT_LINE_N_OE,
   // Status bits
   output logic             STATUS_BYTE_UNKNOWN,
   output logic             STATUS_WORD_INPUT,
   output logic             STATUS_WORD_UNKNOWN,
   output logic             OVERPOWER_WARN_FLAG,
   output logic             OVERCURRENT_WARN_FLAG,
   output logic             ENERGY_OVERFLOW_WARN_FLAG,
   // Event log
   input  wire logic        LOG_CLEAR,
   input  wire logic [2:0]  LOG_RD_ADDR,
   output logic      [15:0] LOG_RD_DATA,
   output logic      [2:0]  EVENT_LOG_POINTER,
   output logic             LOG_FULL,
   // Analog and pin configuration
   output logic      [5:0]  CURRENT_REF_DAC_CODE,
   output logic      [2:0]  AUX_PIN_ONE_FUNC,
   output logic             AUX_PIN_ONE_LEVEL,
   output logic             AUX_PIN_ONE_GP_OUT,
   output logic      [2:0]  AUX_PIN_TWO_FUNC,
   output logic             AUX_PIN_TWO_LEVEL,
   output logic             AUX_PIN_TWO_GP_OUT
);

   function automatic logic pin_is_gp_out(input logic [2:0] func);
      pin_is_gp_out = (func == IWPC_PIN_GP_OUT);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Reset release through two flip-flops
   logic rst_meta_ff;
   logic rst_n_ff;

   always_ff @(posedge SYS_CLK or negedge RESETN) begin
      if (!RESETN) begin
         rst_meta_ff <= 1'b0;
         rst_n_ff    <= 1'b0;
      end else begin
         rst_meta_ff <= 1'b1;
         rst_n_ff    <= rst_meta_ff;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Configuration registers and command answers
   logic [7:0]  oc_limit_ff,  nxt_oc_limit;
   logic [5:0]  cur_ref_ff,   nxt_cur_ref;
   logic [7:0]  pin_cfg_ff,   nxt_pin_cfg;
   logic        done_ff,      nxt_done;
   logic        err_ff,       nxt_err;
   logic [15:0] rd_data_ff,   nxt_rd_data;
   logic        clr_faults;

   assign clr_faults = CMD_VALID && CMD_WRITE && (CMD_CODE == CMD_CLEAR_FAULTS);

   always_comb begin
      nxt_oc_limit = oc_limit_ff;
      nxt_cur_ref  = cur_ref_ff;
      nxt_pin_cfg  = pin_cfg_ff;
      nxt_done     = CMD_VALID;
      nxt_err      = 1'b0;
      nxt_rd_data  = rd_data_ff;
      if (CMD_VALID) begin
         // Upper byte of the limit word is not stored and reads zero
         if (CMD_CODE == CMD_OVERCURRENT_WARN_FLAG_LIMIT) begin // see [R10] see [R11]
            if (CMD_WRITE) begin
               nxt_oc_limit = CMD_WDATA[7:0];
            end else begin
               nxt_rd_data = {8'h00, oc_limit_ff};
            end
         end else if (CMD_CODE == CMD_CUR_REF_CODE) begin // see [R12]
            if (CMD_WRITE) begin
               nxt_cur_ref = CMD_WDATA[5:0];
            end else begin
               nxt_rd_data = {10'h000, cur_ref_ff};
            end
         end else if (CMD_CODE == CMD_PIN_PAIR_A) begin // see [R15]
            if (CMD_WRITE) begin
               nxt_pin_cfg = CMD_WDATA[7:0];
            end else begin
               nxt_rd_data = {8'h00, pin_cfg_ff};
            end
         end else if (CMD_CODE == CMD_CLEAR_FAULTS && CMD_WRITE) begin
            nxt_rd_data = rd_data_ff;
         end else begin
            nxt_err     = 1'b1;
            nxt_rd_data = 16'h0000;
         end
      end
   end

   always_ff @(posedge SYS_CLK or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         oc_limit_ff <= OC_LIMIT_RESET;
         cur_ref_ff  <= CUR_REF_RESET;
         pin_cfg_ff  <= PIN_PAIR_A_RESET;
         done_ff     <= 1'b0;
         err_ff      <= 1'b0;
         rd_data_ff  <= 16'h0000;
      end else begin
         oc_limit_ff <= nxt_oc_limit;
         cur_ref_ff  <= nxt_cur_ref;
         pin_cfg_ff  <= nxt_pin_cfg;
         done_ff     <= nxt_done;
         err_ff      <= nxt_err;
         rd_data_ff  <= nxt_rd_data;
      end
   end

   assign CMD_DONE             = done_ff;
   assign CMD_ERR              = err_ff;
   assign RD_DATA              = rd_data_ff;
   assign CURRENT_REF_DAC_CODE = cur_ref_ff; // see [R13]
   assign AUX_PIN_ONE_FUNC     = pin_cfg_ff[PIN1_FUNC_LSB +: 3]; // see [R16]
   assign AUX_PIN_ONE_LEVEL    = pin_cfg_ff[PIN1_LEVEL_BIT]; // see [R17]
   assign AUX_PIN_TWO_FUNC     = pin_cfg_ff[PIN2_FUNC_LSB +: 3]; // see [R18]
   assign AUX_PIN_TWO_LEVEL    = pin_cfg_ff[PIN2_LEVEL_BIT]; // see [R18]
   assign AUX_PIN_ONE_GP_OUT   = pin_is_gp_out(pin_cfg_ff[PIN1_FUNC_LSB +: 3]);
   assign AUX_PIN_TWO_GP_OUT   = pin_is_gp_out(pin_cfg_ff[PIN2_FUNC_LSB +: 3]);

   ////////////////////////////////////////////////////////////////////////////
   // Time stamp: one enable pulse per tick, no second clock
   logic [31:0]        div_ff,   nxt_div;
   logic [STAMP_W-1:0] stamp_ff, nxt_stamp;

   always_comb begin
      nxt_div   = div_ff + 32'd1;
      nxt_stamp = stamp_ff;
      if (div_ff >= 32'(STAMP_DIV - 1)) begin
         nxt_div   = 32'd0;
         nxt_stamp = stamp_ff + 1'b1;
      end
   end

   always_ff @(posedge SYS_CLK or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         div_ff   <= 32'd0;
         stamp_ff <= '0;
      end else begin
         div_ff   <= nxt_div;
         stamp_ff <= nxt_stamp;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Warning flags, status summary, alert and event log
   logic       oc_above_ff,  nxt_oc_above;
   logic       op_flag_ff,   nxt_op_flag;
   logic       oc_flag_ff,   nxt_oc_flag;
   logic       en_flag_ff,   nxt_en_flag;
   logic       byte_unk_ff,  nxt_byte_unk;
   logic       word_in_ff,   nxt_word_in;
   logic       word_unk_ff,  nxt_word_unk;
   logic       alert_ff,     nxt_alert;
   logic       op_pend_ff,   nxt_op_pend;
   logic       oc_pend_ff,   nxt_oc_pend;
   logic [2:0] ptr_ff,       nxt_ptr;
   logic [2:0] cnt_ff,       nxt_cnt;
   logic       op_evt;
   logic       oc_evt;
   logic       log_full;
   logic       log_wr;
   logic [3:0] log_id;

   // A warning counts as a new event only while its flag is still clear
   assign op_evt   = OVERPOWER_DETECT && !op_flag_ff;
   assign oc_evt   = oc_above_ff && !oc_flag_ff;
   assign log_full = (32'(cnt_ff) >= LOG_SLOTS);
   // Overpower wins a tie; the overcurrent entry follows one cycle later
   assign log_wr   = (op_pend_ff || oc_pend_ff) && !log_full; // see [R4]
   assign log_id   = op_pend_ff ? EVT_OVERPOWER : EVT_OVERCURRENT;

   always_comb begin
      nxt_oc_above = oc_above_ff;
      if (IMON_VALID) begin
         nxt_oc_above = (IMON_VALUE > oc_limit_ff); // see [R8]
      end
      // Set wins over clear; clear only takes once the level is back below
      nxt_op_flag  = OVERPOWER_DETECT || (op_flag_ff && !clr_faults); // see [R1]
      nxt_oc_flag  = oc_above_ff || (oc_flag_ff && !clr_faults); // see [R2] see [R9]
      nxt_en_flag  = ((op_evt || oc_evt) && ENERGY_OVERFLOW)
                     || (en_flag_ff && !clr_faults); // see [R3]
      nxt_byte_unk = nxt_op_flag || nxt_oc_flag; // see [R1] see [R2]
      nxt_word_in  = nxt_op_flag || nxt_oc_flag;
      nxt_word_unk = nxt_op_flag;
      nxt_alert    = (nxt_op_flag || nxt_oc_flag) && !ALERT_MASK_INPUT
                     && ALERT_PIN_SELECTED; // see [R7]
      // Pending events with no free slot are dropped
      nxt_op_pend  = op_evt || (op_pend_ff && !log_wr && !log_full);
      nxt_oc_pend  = oc_evt || (oc_pend_ff && !(log_wr && !op_pend_ff) && !log_full);
      nxt_ptr      = ptr_ff; // see [R6]
      nxt_cnt      = LOG_CLEAR ? 3'h0 : cnt_ff;
      if (log_wr) begin
         nxt_ptr = (ptr_ff < LOG_PTR_LAST) ? ptr_ff + 3'h1 : 3'h0; // see [R5]
         // A write in the clearing cycle still holds its slot
         nxt_cnt = LOG_CLEAR ? 3'h1 : cnt_ff + 3'h1;
      end
   end

   always_ff @(posedge SYS_CLK or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         oc_above_ff <= 1'b0;
         op_flag_ff  <= 1'b0;
         oc_flag_ff  <= 1'b0;
         en_flag_ff  <= 1'b0;
         byte_unk_ff <= 1'b0;
         word_in_ff  <= 1'b0;
         word_unk_ff <= 1'b0;
         alert_ff    <= 1'b0;
         op_pend_ff  <= 1'b0;
         oc_pend_ff  <= 1'b0;
         ptr_ff      <= 3'h0;
         cnt_ff      <= 3'h0;
      end else begin
         oc_above_ff <= nxt_oc_above;
         op_flag_ff  <= nxt_op_flag;
         oc_flag_ff  <= nxt_oc_flag;
         en_flag_ff  <= nxt_en_flag;
         byte_unk_ff <= nxt_byte_unk;
         word_in_ff  <= nxt_word_in;
         word_unk_ff <= nxt_word_unk;
         alert_ff    <= nxt_alert;
         op_pend_ff  <= nxt_op_pend;
         oc_pend_ff  <= nxt_oc_pend;
         ptr_ff      <= nxt_ptr;
         cnt_ff      <= nxt_cnt;
      end
   end

   iwpc_log_mem #(
      .DEPTH (LOG_SLOTS),
      .WIDTH (16)
   ) u_log_mem (
      .clk     (SYS_CLK),
      .wr_en   (log_wr),
      .wr_addr (ptr_ff),
      .wr_data ({log_id, stamp_ff}),
      .rd_addr (LOG_RD_ADDR),
      .rd_data (LOG_RD_DATA)
   );

   // Open-drain alert: only ever pulls low
   assign ALERT_LINE_N_O            = 1'b0;
   assign ALERT_LINE_N_OE           = alert_ff;
   assign STATUS_BYTE_UNKNOWN       = byte_unk_ff;
   assign STATUS_WORD_INPUT         = word_in_ff;
   assign STATUS_WORD_UNKNOWN       = word_unk_ff;
   assign OVERPOWER_WARN_FLAG       = op_flag_ff;
   assign OVERCURRENT_WARN_FLAG     = oc_flag_ff;
   assign ENERGY_OVERFLOW_WARN_FLAG = en_flag_ff;
   assign EVENT_LOG_POINTER         = ptr_ff;
   assign LOG_FULL                  = log_full;

   ////////////////////////////////////////////////////////////////////////////
   // Assertions
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!rst_n_ff);

   op_status_a: assert property ( // see [R1]
      op_flag_ff |-> byte_unk_ff && word_in_ff && word_unk_ff)
      else $error("overpower flag without status summary bits");
   oc_status_a: assert property ( // see [R2]
      oc_flag_ff |-> byte_unk_ff && word_in_ff)
      else $error("overcurrent flag without status summary bits");
   energy_set_a: assert property ( // see [R3]
      (op_evt || oc_evt) && ENERGY_OVERFLOW |=> en_flag_ff)
      else $error("energy overflow flag not set on warning");
   op_logged_a: assert property ( // see [R4]
      op_evt && !op_pend_ff && !oc_pend_ff && !log_full
      |=> log_wr && log_id == EVT_OVERPOWER)
      else $error("overpower event not logged");
   ptr_wrap_a: assert property ( // see [R5]
      log_wr && ptr_ff == LOG_PTR_LAST |=> ptr_ff == 3'h0)
      else $error("log pointer did not wrap");
   ptr_step_a: assert property ( // see [R5]
      log_wr && ptr_ff < LOG_PTR_LAST |=> ptr_ff == $past(ptr_ff) + 3'h1)
      else $error("log pointer did not step");
   ptr_hold_a: assert property ( // see [R6]
      !log_wr |=> $stable(ptr_ff))
      else $error("log pointer moved without a log write");
   alert_gate_a: assert property ( // see [R7]
      ALERT_LINE_N_OE |-> !$past(ALERT_MASK_INPUT) && $past(ALERT_PIN_SELECTED))
      else $error("alert driven while masked or pin not selected");
   oc_raise_a: assert property ( // see [R8]
      IMON_VALID && IMON_VALUE > oc_limit_ff |=> ##1 oc_flag_ff)
      else $error("overcurrent flag not raised");
   oc_clear_a: assert property ( // see [R9]
      $fell(oc_flag_ff) |-> $past(clr_faults) && !$past(oc_above_ff))
      else $error("overcurrent flag cleared without cause");
   ref_write_a: assert property ( // see [R12]
      CMD_VALID && CMD_WRITE && CMD_CODE == CMD_CUR_REF_CODE
      |=> CURRENT_REF_DAC_CODE == $past(CMD_WDATA[5:0]))
      else $error("reference code not written");

   op_log_c:  cover property (log_wr && log_id == EVT_OVERPOWER);
   wrap_c:    cover property (log_wr && ptr_ff == LOG_PTR_LAST);
   oc_clr_c:  cover property ($fell(oc_flag_ff));
   full_c:    cover property ((op_pend_ff || oc_pend_ff) && log_full);

endmodule // iwpc_regs

`default_nettype wire

// file: verilog/iwpc_pkg.sv
// Constants and types of the input warning and pin configuration register block.
// Assumes a command layer upstream that has already decoded the serial transfers.
`default_nettype none

package iwpc_pkg;

   // Command codes
   localparam logic [7:0]  CMD_CLEAR_FAULTS   = 8'h03;
   localparam logic [7:0]  CMD_OVERCURRENT_WARN_FLAG_LIMIT  = 8'h5D;
   localparam logic [7:0]  CMD_CUR_REF_CODE   = 8'hE0;
   localparam logic [7:0]  CMD_PIN_PAIR_A     = 8'hE1;

   // Values after reset
   localparam logic [7:0]  OC_LIMIT_RESET     = 8'hFF;
   localparam logic [5:0]  CUR_REF_RESET      = 6'h32;
   localparam logic [7:0]  PIN_PAIR_A_RESET   = 8'h00;

   // Field positions of the pin pair register
   localparam int          PIN1_FUNC_LSB      = 5;
   localparam int          PIN1_LEVEL_BIT     = 4;
   localparam int          PIN2_FUNC_LSB      = 1;
   localparam int          PIN2_LEVEL_BIT     = 0;

   // Event log
   localparam int          LOG_SLOTS          = 7;
   localparam logic [2:0]  LOG_PTR_LAST       = 3'h6;
   localparam logic [3:0]  EVT_OVERPOWER      = 4'h1;
   localparam logic [3:0]  EVT_OVERCURRENT    = 4'h2;
   localparam int          STAMP_W            = 12;

   // Time stamp rate
   localparam int          CLK_PERIOD_NS      = 10;
   localparam int          STAMP_TICK_NS      = 1000000;
   localparam int          STAMP_TICK_CYCLES  = STAMP_TICK_NS / CLK_PERIOD_NS;

   // Pin functions; code zero is the pin's dedicated output
   typedef enum logic [2:0] {
      IWPC_PIN_DEDICATED = 3'b000,
      IWPC_PIN_GP_IN     = 3'b001,
      IWPC_PIN_GP_OUT    = 3'b010,
      IWPC_PIN_COMP_TWO  = 3'b011,
      IWPC_PIN_COMP_ONE  = 3'b100,
      IWPC_PIN_EE_CLOCK  = 3'b101,
      IWPC_PIN_EE_DATA   = 3'b110,
      IWPC_PIN_RESERVED  = 3'b111
   } iwpc_pin_func_t;

endpackage

`default_nettype wire

// file: verilog/iwpc_log_mem.sv
// Small event log memory: one write port, registered read data.
// Assumes writes and reads are both synchronous to the one system clock.
`default_nettype none

module iwpc_log_mem
   import iwpc_pkg::*;
#(
   parameter int DEPTH = LOG_SLOTS,
   parameter int WIDTH = 16
) (
   // Clock
   input  wire logic                      clk,
   // Write port
   input  wire logic                      wr_en,
   input  wire logic [$clog2(DEPTH)-1:0]  wr_addr,
   input  wire logic [WIDTH-1:0]          wr_data,
   // Read port
   input  wire logic [$clog2(DEPTH)-1:0]  rd_addr,
   output logic      [WIDTH-1:0]          rd_data
);

   logic [WIDTH-1:0] mem [DEPTH];

   // Contents carry no reset: a slot is only read back once the log has filled it
   always_ff @(posedge clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
      if (32'(rd_addr) < DEPTH) begin
         rd_data <= mem[rd_addr];
      end else begin
         rd_data <= '0;
      end
   end

endmodule // iwpc_log_mem

`default_nettype wire

// file: dv/iwpc_host_model.sv
// Host controller model: issues one decoded command at a time on the command port.
// Assumes a free running clock and a bench that calls xfer from its main sequence.
`default_nettype none

module iwpc_host_model (
   // Clock
   input  wire logic        SYS_CLK,
   // Command port
   output logic             CMD_VALID,
   output logic             CMD_WRITE,
   output logic [7:0]       CMD_CODE,
   output logic [15:0]      CMD_WDATA,
   input  wire logic        CMD_DONE,
   input  wire logic        CMD_ERR,
   input  wire logic [15:0] RD_DATA
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      CMD_VALID = 1'b0;
      CMD_WRITE = 1'b0;
      CMD_CODE  = 8'h00;
      CMD_WDATA = 16'h0000;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Write protect is not modelled here; a real host unlocks before writing
   task automatic xfer(input logic wr, input logic [7:0] code, input logic [15:0] wd,
                       output logic [15:0] rd, output logic err, output logic ok);
      @(posedge SYS_CLK);
      CMD_VALID <= 1'b1;
      CMD_WRITE <= wr;
      CMD_CODE  <= code;
      CMD_WDATA <= wd;
      @(posedge SYS_CLK);
      CMD_VALID <= 1'b0;
      // Idle lines carry inverted leftovers so stale data never passes for fresh
      CMD_CODE  <= ~code;
      CMD_WDATA <= ~wd;
      #1;
      ok  = (CMD_DONE === 1'b1);
      rd  = RD_DATA;
      err = CMD_ERR;
   endtask
endmodule // iwpc_host_model

`default_nettype wire

// file: dv/tb.sv
// Self-checking bench for the input warning and pin configuration register block.
// Assumes the host model owns the command port; telemetry is driven from here.
`default_nettype none

module tb;
   import iwpc_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;

   logic        sys_clk = 1'b0;
   logic        resetn = 1'b0;
   logic        cmd_valid, cmd_write, cmd_done, cmd_err;
   logic [7:0]  cmd_code;
   logic [15:0] cmd_wdata, rd_data, log_rd_data;
   logic        op_det = 1'b0, imon_valid = 1'b0, energy_ovf = 1'b0;
   logic [7:0]  imon_value = 8'h00;
   logic        alert_mask = 1'b0, alert_sel = 1'b1, alert_oe, log_clear = 1'b0, log_full;
   logic        st_byte_unk, st_word_in, st_word_unk, op_flag, oc_flag, en_flag;
   logic [2:0]  log_rd_addr = 3'h0, log_ptr, p1_func, p2_func;
   logic        p1_lvl, p1_gp, p2_lvl, p2_gp, alert_o;
   logic [5:0]  dac_code;
   logic [15:0] seed = 16'hF4F7;
   int          fails = 0, comparisons = 0, cnt = 2;
   logic [2:0]  ptr = 3'h2;
   logic [15:0] r;
   logic [7:0]  w;

   always #5 sys_clk = ~sys_clk;

   iwpc_host_model host (.SYS_CLK(sys_clk), .CMD_VALID(cmd_valid), .CMD_WRITE(cmd_write),
      .CMD_CODE(cmd_code), .CMD_WDATA(cmd_wdata), .CMD_DONE(cmd_done), .CMD_ERR(cmd_err),
      .RD_DATA(rd_data));

   // Short stamp tick keeps the run brief
   iwpc_regs #(.STAMP_DIV(4)) dut (.SYS_CLK(sys_clk), .RESETN(resetn),
      .CMD_VALID(cmd_valid), .CMD_WRITE(cmd_write), .CMD_CODE(cmd_code),
      .CMD_WDATA(cmd_wdata), .CMD_DONE(cmd_done), .CMD_ERR(cmd_err), .RD_DATA(rd_data),
      .OVERPOWER_DETECT(op_det), .IMON_VALID(imon_valid), .IMON_VALUE(imon_value),
      .ENERGY_OVERFLOW(energy_ovf), .ALERT_MASK_INPUT(alert_mask),
      .ALERT_PIN_SELECTED(alert_sel), .ALERT_LINE_N_O(alert_o), .ALERT_LINE_N_OE(alert_oe),
      .STATUS_BYTE_UNKNOWN(st_byte_unk), .STATUS_WORD_INPUT(st_word_in),
      .STATUS_WORD_UNKNOWN(st_word_unk), .OVERPOWER_WARN_FLAG(op_flag),
      .OVERCURRENT_WARN_FLAG(oc_flag), .ENERGY_OVERFLOW_WARN_FLAG(en_flag),
      .LOG_CLEAR(log_clear), .LOG_RD_ADDR(log_rd_addr), .LOG_RD_DATA(log_rd_data),
      .EVENT_LOG_POINTER(log_ptr), .LOG_FULL(log_full), .CURRENT_REF_DAC_CODE(dac_code),
      .AUX_PIN_ONE_FUNC(p1_func), .AUX_PIN_ONE_LEVEL(p1_lvl), .AUX_PIN_ONE_GP_OUT(p1_gp),
      .AUX_PIN_TWO_FUNC(p2_func), .AUX_PIN_TWO_LEVEL(p2_lvl), .AUX_PIN_TWO_GP_OUT(p2_gp));

   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [15:0] lfsr();
      seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
      return seed;
   endfunction

   task automatic report_and_stop();
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fails++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic step(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask

   task automatic cmd(input logic wr, input logic [7:0] code, input logic [15:0] wd,
                      input logic [15:0] exp_rd, input logic exp_err);
      logic [15:0] rd;
      logic        err, ok;
      host.xfer(wr, code, wd, rd, err, ok);
      if (!ok) begin
         fails++;
         report_and_stop();
      end
      check(16'(err), 16'(exp_err));
      if (!wr) check(rd, exp_rd);
   endtask

   task automatic sample(input logic [7:0] v);
      @(posedge sys_clk);
      imon_valid <= 1'b1;
      imon_value <= v;
      @(posedge sys_clk);
      imon_valid <= 1'b0;
      imon_value <= ~v;
      step(5);
   endtask

   task automatic op_event();
      @(posedge sys_clk);
      op_det <= 1'b1;
      step(3);
      @(posedge sys_clk);
      op_det <= 1'b0;
      step(1);
      cmd(1'b1, CMD_CLEAR_FAULTS, 16'h0000, 16'h0000, 1'b0);
      step(3);
      if (cnt < 7) begin
         ptr = (ptr < 3'h6) ? ptr + 3'h1 : 3'h0;
         cnt++;
      end
      check(16'(log_ptr), 16'(ptr));
   endtask

   // Bounded run: a hang counts as a mismatch
   initial begin
      repeat (20000) @(posedge sys_clk);
      fails++;
      report_and_stop();
   end

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (2) @(posedge sys_clk);
      resetn <= 1'b1;
      step(3);
      cmd(1'b0, CMD_OVERCURRENT_WARN_FLAG_LIMIT, 16'h0000, 16'h00FF, 1'b0);
      cmd(1'b0, CMD_CUR_REF_CODE, 16'h0000, 16'h0032, 1'b0);
      check(16'(dac_code), 16'h0032);
      cmd(1'b0, CMD_PIN_PAIR_A, 16'h0000, 16'h0000, 1'b0);
      for (int i = 0; i < 8; i++) begin
         r = lfsr();
         w = {3'(i), r[4], 3'(7 - i), r[0]};
         cmd(1'b1, CMD_PIN_PAIR_A, {r[15:8], w}, 16'h0000, 1'b0);
         check(16'(p1_func), 16'(w[7:5]));
         check(16'(p1_lvl), 16'(w[4]));
         check(16'(p1_gp), 16'(w[7:5] == 3'b010));
         check(16'({p2_func, p2_lvl}), 16'(w[3:0]));
         check(16'(p2_gp), 16'(w[3:1] == 3'b010));
         cmd(1'b0, CMD_PIN_PAIR_A, 16'h0000, {8'h00, w}, 1'b0);
      end
      for (int j = 0; j < 2; j++) begin
         r = j ? 16'hFFFF : lfsr();
         cmd(1'b1, CMD_CUR_REF_CODE, r, 16'h0000, 1'b0);
         check(16'(dac_code), 16'(r[5:0]));
         cmd(1'b0, CMD_CUR_REF_CODE, 16'h0000, 16'(r[5:0]), 1'b0);
      end
      r = lfsr();
      cmd(1'b1, CMD_OVERCURRENT_WARN_FLAG_LIMIT, r, 16'h0000, 1'b0);
      cmd(1'b0, CMD_OVERCURRENT_WARN_FLAG_LIMIT, 16'h0000, {8'h00, r[7:0]}, 1'b0);
      cmd(1'b1, 8'h5C, 16'h0011, 16'h0000, 1'b1);
      cmd(1'b0, 8'h7A, 16'h0000, 16'h0000, 1'b1);
      // Clear faults is write only; reading it is refused
      cmd(1'b0, CMD_CLEAR_FAULTS, 16'h0000, 16'h0000, 1'b1);
      cmd(1'b1, CMD_OVERCURRENT_WARN_FLAG_LIMIT, 16'h0080, 16'h0000, 1'b0);
      sample(8'h80);
      check(16'({oc_flag, alert_oe}), 16'h0000);
      sample(8'h81);
      check(16'(oc_flag), 16'h0001);
      check(16'({st_byte_unk, st_word_in, st_word_unk, en_flag}), 16'h000C);
      check(16'({alert_o, alert_oe}), 16'h0001);
      check(16'(log_ptr), 16'h0001);
      step(2);
      check(16'(log_rd_data[15:12]), 16'(EVT_OVERCURRENT));
      r = {4'h0, log_rd_data[11:0]};
      @(posedge sys_clk);
      alert_sel <= 1'b0;
      step(2);
      check(16'({oc_flag, alert_oe}), 16'h0002);
      @(posedge sys_clk);
      alert_sel <= 1'b1;
      cmd(1'b1, CMD_CLEAR_FAULTS, 16'h0000, 16'h0000, 1'b0);
      check(16'({oc_flag, alert_oe}), 16'h0003);
      sample(8'h10);
      cmd(1'b1, CMD_CLEAR_FAULTS, 16'h0000, 16'h0000, 1'b0);
      step(1);
      check(16'({oc_flag, alert_oe}), 16'h0000);
      @(posedge sys_clk);
      alert_mask <= 1'b1;
      energy_ovf <= 1'b1;
      op_det     <= 1'b1;
      log_rd_addr <= 3'h1;
      step(4);
      check(16'({op_flag, st_word_unk, st_byte_unk}), 16'h0007);
      check(16'(en_flag), 16'h0001);
      check(16'(alert_oe), 16'h0000);
      check(16'(log_ptr), 16'h0002);
      check(16'(log_rd_data[15:12]), 16'(EVT_OVERPOWER));
      // Later entry carries a later stamp
      check(16'(log_rd_data[11:0] > r[11:0]), 16'h0001);
      @(posedge sys_clk);
      op_det <= 1'b0;
      step(1);
      cmd(1'b1, CMD_CLEAR_FAULTS, 16'h0000, 16'h0000, 1'b0);
      step(1);
      check(16'({op_flag, en_flag}), 16'h0000);
      for (int k = 0; k < 6; k++) op_event();
      check(16'(log_full), 16'h0001);
      @(posedge sys_clk);
      log_clear <= 1'b1;
      @(posedge sys_clk);
      log_clear <= 1'b0;
      cnt = 0;
      op_event();
      report_and_stop();
   end
endmodule // tb

`default_nettype wire
